//--- chs_host_port.sv
// Purpose: Host serial port of a coprocessor: SPI mode 0 slave or two-wire slave
// Assumes: Pins are asynchronous and pass two flip-flops; MODE_PARAM0 and SLAVE_ADDR
//          are static after reset; the serial clock is far slower than CLK
// Notes:   Only the serial front end; execution and the debug monitor stay outside
//
// Notes on behaviour
// - Select pin high at reset selects the two-wire slave instead of SPI.
// - Mode byte 0 bits 1:0 equal to 11 selects SPI bus mode.
// - Bus mode forces SPI at reset; select pin becomes active-low slave select.
// - Bus mode: data output pin floats whenever the device is not selected.
// - SPI mode 0: clock idles low, sample on rise, shift on fall, MSB first.
// - Nine consecutive 0xFF bytes on the data input arm an SPI reset.
// - Armed reset fires when data input goes low; host sends 0x00 if needed.
// - Armed reset fires anyway 100 ms after the last 0xFF byte.
// - Busy is raised as soon as any instruction byte is received.
// - Ready only when instruction buffer and trace buffer are both empty.
// - On SPI the data output is low when Ready and high when Busy.
// - Two-wire slave answers a 7-bit address, default 0x64, then direction bit.
// - Two-wire transfers up to 400 kHz are supported.
// - Write: address, register byte, data bytes; a read follows a selecting write.
// - Writing zero to register 1 resets the device.
// - Register 0 writes feed instructions; reads give pending byte or status.
// - Status byte is 0x00 when Ready and 0x80 when Busy.
// - Register 1 reads return free space in the instruction buffer.
`include "chs_host_port_cfg.svh"

module chs_host_port
  import chs_host_port_pkg::*;
#(
  parameter int unsigned ARM_TIMEOUT_CYC =
    32'((`CHS_ARM_TIMEOUT_MS * `CHS_CLK_HZ) / `CHS_MS_PER_S),
  parameter int unsigned FREE_W          = 9
)
(
  input  wire logic              CLK,
  input  wire logic              RST_N,
  input  wire logic              SEL_PIN,
  input  wire logic              SCLK_PIN,
  input  wire logic              SERIAL_DATA_IN_PIN_I,
  output logic                   SERIAL_DATA_IN_PIN_O,
  output logic                   SERIAL_DATA_IN_PIN_OE,
  input  wire logic              SERIAL_DATA_OUT_PIN_I,
  output logic                   SERIAL_DATA_OUT_PIN_O,
  output logic                   SERIAL_DATA_OUT_PIN_OE,
  input  wire logic [7:0]        MODE_PARAM0,
  input  wire logic [6:0]        SLAVE_ADDR,
  input  wire logic              INSTR_BUF_EMPTY,
  input  wire logic              TRACE_BUF_EMPTY,
  input  wire logic [FREE_W-1:0] FREE_BYTES,
  input  wire chs_byte_s         TX_BYTE,
  output chs_byte_s              RX_BYTE,
  output logic                   TX_TAKE,
  output logic                   CORE_RESET,
  output logic                   I2C_MODE,
  output logic                   BUSY
);

  localparam int TW = $clog2(ARM_TIMEOUT_CYC + 1);

  // Synchroniser chain: select, SPI clock, data in / SDA, data out / SCL
  logic [3:0]     sy1_r;
  logic [3:0]     sy2_r;
  logic [3:0]     sy3_r;
  logic           sel_s;
  logic           sck_s;
  logic           sin_s;
  logic           scl_s;
  logic           sck_rise;
  logic           sck_fall;
  logic           scl_rise;
  logic           scl_fall;
  logic           sda_fall;
  logic           sda_rise;
  logic           bus_mode;
  logic           cap_r;
  logic           i2c_r;
  logic           spi_en;
  logic           spi_sel;
  logic [2:0]     sbit_r;
  logic [7:0]     srx_r;
  logic [7:0]     stx_r;
  logic           txact_r;
  logic           spi_byte;
  logic [7:0]     spi_val;
  logic [3:0]     ffcnt_r;
  logic           armed;
  logic [TW-1:0]  tmr_r;
  logic           spi_fire;
  chs_i2c_e       st_r;
  logic [2:0]     ibit_r;
  logic [7:0]     ish_r;
  logic           first_r;
  logic           rd_r;
  logic           ptr_r;
  logic           sda_oe_r;
  logic [7:0]     rval;
  logic [7:0]     iwval;
  logic           i2c_wr0;
  logic           i2c_rst;
  logic           i2c_take;
  logic           busy_r;
  logic           rxv_r;
  logic           core_rst_r;
  logic           serial_data_out_pin_r;
  logic           serial_data_out_pin_oe_r;
  logic           sdi_o_r;
  logic           take_r;
  chs_byte_s      rx_r;

  // Two flip-flops on every pin, plus a third stage for edge finding
  always_ff @(posedge CLK)
  begin
    sy1_r <= {SEL_PIN, SCLK_PIN, SERIAL_DATA_IN_PIN_I, SERIAL_DATA_OUT_PIN_I};
    sy2_r <= sy1_r;
    sy3_r <= sy2_r;
  end

  // Synchronised levels and edges
  assign sel_s    = sy2_r[3];
  assign sck_s    = sy2_r[2];
  assign sin_s    = sy2_r[1];
  assign scl_s    = sy2_r[0];
  assign sck_rise = sck_s & ~sy3_r[2];
  assign sck_fall = ~sck_s & sy3_r[2];
  assign scl_rise = scl_s & ~sy3_r[0]; // About 100 CLK per bit at 400 kHz
  assign scl_fall = ~scl_s & sy3_r[0];
  assign sda_fall = scl_s & sy3_r[0] & ~sin_s & sy3_r[1];
  assign sda_rise = scl_s & sy3_r[0] & sin_s & ~sy3_r[1];

  // Bus mode decode from the stored mode byte
  assign bus_mode = MODE_PARAM0[`CHS_MODE_BUS_MSB:`CHS_MODE_BUS_LSB]
                    == `CHS_MODE_BUS_VAL;

  // Interface choice caught once on the first edge after reset release
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      cap_r <= 1'b0;
      i2c_r <= 1'b0;
    end
    else if (!cap_r)
    begin
      cap_r <= 1'b1;
      i2c_r <= sel_s & ~bus_mode;
    end
  end

  // SPI is live after the choice; in bus mode the select pin gates it
  assign spi_en  = cap_r & ~i2c_r;
  assign spi_sel = spi_en & (~bus_mode | ~sel_s);

  // SPI byte completes on the eighth rising edge
  assign spi_val  = {srx_r[6:0], sin_s};
  assign spi_byte = spi_sel & sck_rise & (sbit_r == 3'h7);

  // SPI shifter: sample on rise, next bit out on fall, MSB first
  always_ff @(posedge CLK)
  begin
    if (!RST_N || !spi_sel || core_rst_r)
    begin
      sbit_r  <= 3'h0;
      srx_r   <= 8'h00;
      stx_r   <= 8'h00;
      txact_r <= 1'b0;
    end
    else if (sck_rise)
    begin
      srx_r  <= spi_val;
      sbit_r <= sbit_r + 3'h1;
      if (sbit_r == 3'h7)
      begin
        txact_r <= 1'b0;
      end
    end
    else if (sck_fall)
    begin
      stx_r <= {stx_r[6:0], 1'b0};
    end
    else if (sbit_r == 3'h0 && !txact_r && TX_BYTE.vld && !sck_s)
    begin
      stx_r   <= TX_BYTE.data;          // Pending output goes out next byte
      txact_r <= 1'b1;
    end
  end

  // Count consecutive 0xFF bytes; a read-out byte is not counted
  always_ff @(posedge CLK)
  begin
    if (!RST_N || spi_fire || !spi_en)
    begin
      ffcnt_r <= 4'h0;
    end
    else if (spi_byte && !txact_r)
    begin
      if (spi_val != `CHS_SYNC_BYTE)
      begin
        ffcnt_r <= 4'h0;
      end
      else if (ffcnt_r != `CHS_SYNC_COUNT)
      begin
        ffcnt_r <= ffcnt_r + 4'h1;
      end
    end
  end

  assign armed = (ffcnt_r == `CHS_SYNC_COUNT);

  // Armed timeout counter, restarted by every further 0xFF byte
  always_ff @(posedge CLK)
  begin
    if (!RST_N || !armed || spi_byte)
    begin
      tmr_r <= '0;
    end
    else if (tmr_r != TW'(ARM_TIMEOUT_CYC - 1))
    begin
      tmr_r <= tmr_r + TW'(1);
    end
  end

  // Reset fires on a low data input or on timeout
  assign spi_fire = armed & (~sin_s | (tmr_r == TW'(ARM_TIMEOUT_CYC - 1)));

  // Two-wire read value: pending byte, status, or free space
  always_comb
  begin
    rval     = busy_r ? `CHS_STAT_BUSY : `CHS_STAT_READY;
    i2c_take = 1'b0;
    if (ptr_r)
    begin
      rval = (FREE_BYTES > FREE_W'(`CHS_FREE_MAX)) ? `CHS_FREE_MAX
                                                 : FREE_BYTES[7:0];
    end
    else if (TX_BYTE.vld)
    begin
      rval     = TX_BYTE.data;
      i2c_take = 1'b1;
    end
  end

  // Byte just received from the two-wire master and its effects
  assign iwval   = {ish_r[6:0], sin_s};
  assign i2c_wr0 = (st_r == CHS_RXB) & scl_rise & (ibit_r == 3'h7) & ~first_r & ~ptr_r;
  assign i2c_rst = (st_r == CHS_RXB) & scl_rise & (ibit_r == 3'h7) & ~first_r & ptr_r
                   & (iwval == `CHS_RESET_CMD);

  // Two-wire slave: start, address, register pointer, data in and out
  always_ff @(posedge CLK)
  begin
    if (!RST_N || !cap_r || !i2c_r || core_rst_r)
    begin
      st_r     <= CHS_IDLE;
      ibit_r   <= 3'h0;
      ish_r    <= 8'h00;
      first_r  <= 1'b0;
      rd_r     <= 1'b0;
      ptr_r    <= 1'b0;
      sda_oe_r <= 1'b0;
    end
    else if (sda_fall)
    begin
      st_r     <= CHS_ADDR;
      ibit_r   <= 3'h0;
      first_r  <= 1'b1;
      sda_oe_r <= 1'b0;
    end
    else if (sda_rise)
    begin
      st_r     <= CHS_IDLE;
      sda_oe_r <= 1'b0;
    end
    else
    begin
      unique case (st_r)
        CHS_IDLE: ;
        CHS_ADDR:
          if (scl_rise)
          begin
            ish_r  <= iwval;
            ibit_r <= ibit_r + 3'h1;
            if (ibit_r == 3'h7)
            begin
              rd_r <= sin_s;
              st_r <= (ish_r[6:0] == SLAVE_ADDR) ? CHS_AACK : CHS_IDLE;
            end
          end
        CHS_AACK:
          if (scl_fall)
          begin
            sda_oe_r <= 1'b1;           // Acknowledge low
            st_r     <= CHS_AHLD;
          end
        CHS_AHLD:
          if (scl_fall)
          begin
            ibit_r <= 3'h0;
            if (rd_r)
            begin
              ish_r    <= rval;
              sda_oe_r <= ~rval[7];
              st_r     <= CHS_TXB;
            end
            else
            begin
              sda_oe_r <= 1'b0;
              st_r     <= CHS_RXB;
            end
          end
        CHS_RXB:
          if (scl_rise)
          begin
            ish_r  <= iwval;
            ibit_r <= ibit_r + 3'h1;
            if (ibit_r == 3'h7)
            begin
              st_r <= CHS_AACK;
              if (first_r)
              begin
                first_r <= 1'b0;
                ptr_r   <= (iwval == `CHS_REG_RESET_FREE);
              end
            end
          end
        CHS_TXB:
          if (scl_rise)
          begin
            ibit_r <= ibit_r + 3'h1;
            if (ibit_r == 3'h7)
            begin
              st_r <= CHS_TREL;
            end
          end
          else if (scl_fall)
          begin
            ish_r    <= {ish_r[6:0], 1'b0};
            sda_oe_r <= ~ish_r[6];      // Open drain: enable drives low
          end
        CHS_TREL:
          if (scl_fall)
          begin
            sda_oe_r <= 1'b0;
            st_r     <= CHS_TACK;
          end
        CHS_TACK:
          if (scl_rise)
          begin
            st_r <= sin_s ? CHS_IDLE : CHS_TLD;
          end
        CHS_TLD:
          if (scl_fall)
          begin
            ibit_r   <= 3'h0;
            ish_r    <= rval;
            sda_oe_r <= ~rval[7];
            st_r     <= CHS_TXB;
          end
        default:
          st_r <= CHS_IDLE;
      endcase
    end
  end

  // Busy set by every received instruction byte; set wins over the clear
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      busy_r <= 1'b0;
      rxv_r  <= 1'b0;
    end
    else
    begin
      rxv_r <= rx_r.vld;
      if (rx_r.vld)
      begin
        busy_r <= 1'b1;
      end
      else if (INSTR_BUF_EMPTY && TRACE_BUF_EMPTY && !rxv_r)
      begin
        busy_r <= 1'b0;
      end
    end
  end

  // Bytes toward the core, output handshakes and the core reset pulse
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      rx_r       <= '0;
      take_r     <= 1'b0;
      core_rst_r <= 1'b0;
    end
    else
    begin
      rx_r.vld   <= (spi_byte & ~txact_r & ~armed & (spi_val != `CHS_SYNC_BYTE))
                    | i2c_wr0;
      rx_r.data  <= i2c_r ? iwval : spi_val;
      take_r     <= (spi_byte & txact_r)
                    | (i2c_take & scl_fall & ((st_r == CHS_AHLD & rd_r) | st_r == CHS_TLD));
      core_rst_r <= spi_fire | i2c_rst;
    end
  end

  // SPI data output: read-out bit, else Busy high / Ready low
  // The next bit is taken at the detected fall, so it stands well before the rise
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      serial_data_out_pin_r    <= 1'b0;
      serial_data_out_pin_oe_r <= 1'b0;
      sdi_o_r   <= 1'b0;
    end
    else
    begin
      serial_data_out_pin_r    <= !txact_r ? busy_r
                   : (sck_fall ? stx_r[6] : stx_r[7]);
      serial_data_out_pin_oe_r <= spi_sel;
      sdi_o_r   <= 1'b0;
    end
  end

  assign SERIAL_DATA_OUT_PIN_O  = serial_data_out_pin_r;
  assign SERIAL_DATA_OUT_PIN_OE = serial_data_out_pin_oe_r;
  assign SERIAL_DATA_IN_PIN_O   = sdi_o_r;
  assign SERIAL_DATA_IN_PIN_OE  = sda_oe_r;
  assign RX_BYTE                = rx_r;
  assign TX_TAKE                = take_r;
  assign CORE_RESET             = core_rst_r;
  assign I2C_MODE               = i2c_r;
  assign BUSY                   = busy_r;

endmodule

//--- chs_host_port_asserts.sv
// Purpose: Port-level assertions for the host serial port
// Assumes: Bound to every chs_host_port instance
// Notes:   Sees only the top module's ports
module chs_host_port_asserts
  import chs_host_port_pkg::*;
(
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       SEL_PIN,
  input wire logic [7:0] MODE_PARAM0,
  input wire logic       INSTR_BUF_EMPTY,
  input wire logic       TRACE_BUF_EMPTY,
  input wire chs_byte_s  TX_BYTE,
  input wire chs_byte_s  RX_BYTE,
  input wire logic       TX_TAKE,
  input wire logic       CORE_RESET,
  input wire logic       I2C_MODE,
  input wire logic       BUSY,
  input wire logic       SERIAL_DATA_OUT_PIN_O,
  input wire logic       SERIAL_DATA_OUT_PIN_OE,
  input wire logic       SERIAL_DATA_OUT_PIN_I,
  input wire logic       SERIAL_DATA_IN_PIN_OE
);
  timeunit 1ns;
  timeprecision 100ps;
  logic both_empty;

  // Both core buffers drained
  assign both_empty = INSTR_BUF_EMPTY && TRACE_BUF_EMPTY;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  busy_on_rx_a:
    assert property (RX_BYTE.vld |=> BUSY) else $error("busy missing after byte");
  ready_empty_a:
    assert property ($fell(BUSY) |-> $past(both_empty)) else $error("ready too early");
  busy_hold_a:
    assert property (BUSY && !both_empty |=> BUSY) else $error("busy dropped");
  serial_data_out_pin_status_a:
    assert property ((SERIAL_DATA_OUT_PIN_OE && !TX_BYTE.vld && $stable(BUSY))[*8]
      |-> SERIAL_DATA_OUT_PIN_O == BUSY) else $error("status level wrong");
  mode_fixed_a:
    assert property ($past(RST_N) && $past(RST_N, 2) && $past(RST_N, 3)
      |-> $stable(I2C_MODE)) else $error("interface choice moved");
  i2c_quiet_a:
    assert property (I2C_MODE |-> !SERIAL_DATA_OUT_PIN_OE) else $error("output driven");
  bus_float_a:
    assert property ((MODE_PARAM0[1:0] == 2'h3 && SEL_PIN)[*4]
      |-> !SERIAL_DATA_OUT_PIN_OE) else $error("output not floating");
  bus_drive_a:
    assert property ((MODE_PARAM0[1:0] == 2'h3 && !SEL_PIN && !I2C_MODE)[*5]
      |-> SERIAL_DATA_OUT_PIN_OE) else $error("selected but not driving");
  ff_dropped_a:
    assert property (!I2C_MODE && RX_BYTE.vld |-> RX_BYTE.data != 8'hff)
      else $error("sync byte forwarded");
  take_pulse_a:
    assert property (TX_TAKE |-> TX_BYTE.vld ##1 !TX_TAKE) else $error("bad take");
  reset_pulse_a:
    assert property (CORE_RESET |=> !CORE_RESET) else $error("reset not a pulse");
  ack_scl_low_a:
    assert property (I2C_MODE && $changed(SERIAL_DATA_IN_PIN_OE) |-> !SERIAL_DATA_OUT_PIN_I)
      else $error("data changed with clock high");

  rx_seen_c: cover property (RX_BYTE.vld);
  reset_seen_c: cover property (CORE_RESET);
  take_seen_c: cover property (TX_TAKE);
endmodule

bind chs_host_port chs_host_port_asserts u_chs_host_port_asserts
(
  .CLK(CLK), .RST_N(RST_N), .SEL_PIN(SEL_PIN), .MODE_PARAM0(MODE_PARAM0),
  .INSTR_BUF_EMPTY(INSTR_BUF_EMPTY), .TRACE_BUF_EMPTY(TRACE_BUF_EMPTY),
  .TX_BYTE(TX_BYTE), .RX_BYTE(RX_BYTE), .TX_TAKE(TX_TAKE), .CORE_RESET(CORE_RESET),
  .I2C_MODE(I2C_MODE), .BUSY(BUSY), .SERIAL_DATA_OUT_PIN_O(SERIAL_DATA_OUT_PIN_O),
  .SERIAL_DATA_OUT_PIN_OE(SERIAL_DATA_OUT_PIN_OE),
  .SERIAL_DATA_OUT_PIN_I(SERIAL_DATA_OUT_PIN_I),
  .SERIAL_DATA_IN_PIN_OE(SERIAL_DATA_IN_PIN_OE)
);

//--- chs_host_port_cfg.svh
// Purpose: Offsets, field positions, values and timing for the host serial port
// Assumes: Included by the host port module only
// Notes:   Times are kept in their own unit; cycle counts are derived in the module
`ifndef CHS_HOST_PORT_CFG_SVH
`define CHS_HOST_PORT_CFG_SVH

// Register addresses seen over the two-wire link
`define CHS_REG_DATA          8'h00
`define CHS_REG_RESET_FREE    8'h01

// Mode parameter byte 0: bus-mode field and its code
`define CHS_MODE_BUS_MSB      1
`define CHS_MODE_BUS_LSB      0
`define CHS_MODE_BUS_VAL      2'h3

// Status bytes and special data values
`define CHS_STAT_READY        8'h00
`define CHS_STAT_BUSY         8'h80
`define CHS_SYNC_BYTE         8'hff
`define CHS_RESET_CMD         8'h00
`define CHS_SYNC_COUNT        4'h9
`define CHS_FREE_MAX          8'hff

// Default two-wire slave address
`define CHS_SLAVE_ADDR_DEF    7'h64

// Clock rate and armed-reset timeout
`define CHS_CLK_HZ            64'd40000000
`define CHS_ARM_TIMEOUT_MS    64'd100
`define CHS_MS_PER_S          64'd1000

`endif

//--- chs_host_port_pkg.sv
// Purpose: Types shared by the host serial port
// Assumes: Constants come from chs_host_port_cfg.svh
// Notes:   Byte carrier is used for both directions toward the core
package chs_host_port_pkg;

  // One byte with its valid flag
  typedef struct packed
  {
    logic       vld;
    logic [7:0] data;
  } chs_byte_s;

  // Two-wire slave states, Gray in the order listed
  typedef enum logic [3:0]
  {
    CHS_IDLE = 4'h0,
    CHS_ADDR = 4'h1,
    CHS_AACK = 4'h3,
    CHS_AHLD = 4'h2,
    CHS_RXB  = 4'h6,
    CHS_TXB  = 4'h7,
    CHS_TREL = 4'h5,
    CHS_TACK = 4'h4,
    CHS_TLD  = 4'hc
  } chs_i2c_e;

endpackage

//--- chs_mcu.sv
// Purpose: Host microcontroller model, SPI mode 0 master and two-wire master
// Assumes: Pins change on CLK rising edges; SDA and SCL have pull-ups
// Notes:   SPI clock period 8 CLK (200 ns); two-wire bit 100 CLK (400 kHz)
module chs_mcu
(
  input  wire logic clk,
  input  wire logic miso,
  input  wire logic sda_w,
  output logic      sclk,
  output logic      mosi,
  output logic      scl
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int Q = 25;

  // Idle levels: SPI clock low, two-wire lines released
  initial
  begin
    sclk = 1'b0;
    mosi = 1'b1;
    scl  = 1'b1;
  end

  // Waits a number of CLK cycles
  task automatic hw(input int n);
    repeat (n) @(posedge clk);
  endtask

  // One SPI byte MSB first, returning what the device shifts out
  task automatic spi(input logic [7:0] d, output logic [7:0] r);
    for (int i = 7; i >= 0; i--)
    begin
      mosi <= d[i]; // Changed while clock low
      hw(4);
      sclk <= 1'b1; // 5 MHz within a byte
      r[i] = miso;  // Sampled on the rise
      hw(4);
      sclk <= 1'b0;
    end
    hw(8); // First-bit rises 1.8 us apart
  endtask

  // Start condition: data falls while clock high
  task automatic start();
    mosi <= 1'b1;
    scl  <= 1'b1;
    hw(Q);
    mosi <= 1'b0;
    hw(Q);
    scl  <= 1'b0;
    hw(Q);
  endtask

  // Stop condition: data rises while clock high
  task automatic stop();
    mosi <= 1'b0;
    hw(Q);
    scl  <= 1'b1;
    hw(Q);
    mosi <= 1'b1;
    hw(Q);
  endtask

  // Eight bits and the acknowledge slot; all ones reads, last is ours to give
  task automatic ib(input logic [7:0] d, input logic last, output logic [7:0] r,
                    output logic a);
    logic [8:0] v;
    logic [8:0] s;
    v = {d, last};
    for (int i = 8; i >= 0; i--)
    begin
      mosi <= v[i]; // Changed while clock low
      hw(Q);
      scl  <= 1'b1; // 400 kHz bit rate
      hw(Q);
      s[i] = sda_w;
      hw(Q);
      scl  <= 1'b0;
      hw(Q);
    end
    r = s[8:1];
    a = s[0];
  endtask
endmodule

//--- tb.sv
// Purpose: Self-checking bench for the host serial port in SPI, bus and two-wire modes
// Assumes: chs_mcu drives the link; the core side is driven here
// Notes:   Armed-reset timeout shortened to 200 cycles
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import chs_host_port_pkg::*;
  localparam int unsigned ARM = 200;
  logic       clk = 1'b0, rst_n = 1'b0, sel = 1'b0, ibe = 1'b1, tbe = 1'b1;
  logic [7:0] mode = 8'h00, rx_d, q;
  logic [8:0] free = 9'h0ff;
  logic [6:0] sadr = 7'h64;
  chs_byte_s  txb = '0, rxb;
  logic       so, soe, di_oe, take, crst, i2c, busy, a;
  int         n_errors = 0, comparisons = 0, n_rx = 0, n_rst = 0, n_take = 0;
  wire        sclk, mosi, scl;
  wire        sin_w = mosi & ~di_oe; // SDA pulled up, either side pulls low
  wire        sdo_w = soe ? so : scl; // Shared pin: SPI output or SCL

  always #12.5 clk = ~clk;

  chs_host_port #(.ARM_TIMEOUT_CYC(ARM)) u_chs_host_port
  (
    .CLK(clk), .RST_N(rst_n), .SEL_PIN(sel), .SCLK_PIN(sclk),
    .SERIAL_DATA_IN_PIN_I(sin_w), .SERIAL_DATA_IN_PIN_O(),
    .SERIAL_DATA_IN_PIN_OE(di_oe), .SERIAL_DATA_OUT_PIN_I(sdo_w),
    .SERIAL_DATA_OUT_PIN_O(so), .SERIAL_DATA_OUT_PIN_OE(soe), .MODE_PARAM0(mode),
    .SLAVE_ADDR(sadr), .INSTR_BUF_EMPTY(ibe), .TRACE_BUF_EMPTY(tbe),
    .FREE_BYTES(free), .TX_BYTE(txb), .RX_BYTE(rxb), .TX_TAKE(take),
    .CORE_RESET(crst), .I2C_MODE(i2c), .BUSY(busy)
  );
  chs_mcu u_chs_mcu
  (
    .clk(clk), .miso(sdo_w), .sda_w(sin_w), .sclk(sclk), .mosi(mosi), .scl(scl)
  );

  // Counts core-side pulses and retires each taken output byte
  always @(posedge clk)
  begin
    if (rxb.vld === 1'b1)
    begin
      n_rx++;
      rx_d = rxb.data;
    end
    if (crst === 1'b1) n_rst++;
    if (take === 1'b1)
    begin
      n_take++;
      txb.vld <= 1'b0;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR %0t: saw %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic end_sim();
    $display("Totals: %0d compared, %0d mismatched", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic boot(input logic s, input logic [7:0] m, input int n);
    rst_n <= 1'b0;
    sel   <= s;
    mode  <= m;
    repeat (n) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
  endtask

  // Two-wire write: address, register, optional data byte
  task automatic iw(input logic [7:0] r, input logic [7:0] d, input logic dat);
    u_chs_mcu.start();
    u_chs_mcu.ib(8'hc8, 1'b1, q, a);
    chk(a, 0);
    u_chs_mcu.ib(r, 1'b1, q, a);
    chk(a, 0);
    if (dat) u_chs_mcu.ib(d, 1'b1, q, a);
    u_chs_mcu.stop();
  endtask

  // Two-wire read of one byte, ended by NAK
  task automatic ir(input logic [7:0] e);
    u_chs_mcu.start();
    u_chs_mcu.ib(8'hc9, 1'b1, q, a);
    u_chs_mcu.ib(8'hff, 1'b1, q, a);
    u_chs_mcu.stop();
    chk(q, e);
  endtask

  // Main sequence
  initial
  begin
    boot(1'b0, 8'h00, 2);
    chk(i2c, 0);
    chk(sdo_w, 0);
    tbe <= 1'b0;
    u_chs_mcu.spi(8'ha5, q);
    chk(rx_d, 8'ha5);
    chk(busy, 1);
    chk(sdo_w, 1);
    tbe <= 1'b1;
    ibe <= 1'b0;
    u_chs_mcu.hw(6);
    chk(busy, 1);
    ibe <= 1'b1;
    sel <= 1'b1;
    u_chs_mcu.hw(6);
    chk(sdo_w, 0); // Ready before reading
    chk(i2c, 0);
    sel <= 1'b0;
    $display("SPI status test done");
    txb <= {1'b1, 8'h3c};
    u_chs_mcu.hw(600); // Read setup delay
    u_chs_mcu.spi(8'h00, q);
    chk(q, 8'h3c);
    txb <= {1'b1, 8'hc3};
    u_chs_mcu.hw(40); // Read byte delay
    u_chs_mcu.spi(8'h00, q);
    chk(q, 8'hc3);
    chk(n_take, 2);
    chk(n_rx, 1);
    $display("SPI read test done");
    repeat (8) u_chs_mcu.spi(8'hff, q);
    u_chs_mcu.spi(8'h00, q);
    chk(n_rst, 0);
    repeat (10) u_chs_mcu.spi(8'hff, q);
    u_chs_mcu.hw(100);
    chk(n_rst, 0);
    u_chs_mcu.spi(8'h00, q);
    chk(n_rst, 1);
    u_chs_mcu.hw(40); // Post-reset pause, scaled down like the timeout
    repeat (9) u_chs_mcu.spi(8'hff, q);
    u_chs_mcu.hw(150);
    chk(n_rst, 1);
    u_chs_mcu.hw(100);
    chk(n_rst, 2);
    $display("SPI resync test done");
    for (int m = 0; m < 4; m++)
    begin
      boot(1'b1, 8'(m * 85), 4); // Upper mode bits vary as well
      chk(i2c, m != 3);
    end
    chk(soe, 0);
    u_chs_mcu.spi(8'h24, q);
    chk(n_rx, 3); // Both zero bytes of the resync test were forwarded
    sel <= 1'b0;
    u_chs_mcu.hw(6);
    chk(soe, 1);
    u_chs_mcu.spi(8'h42, q);
    chk(rx_d, 8'h42);
    sel <= 1'b1;
    u_chs_mcu.hw(6);
    chk(soe, 0);
    $display("Bus mode test done");
    boot(1'b1, 8'h00, 4);
    sel <= 1'b0;
    ibe <= 1'b0;
    iw(8'h00, 8'h5a, 1'b1);
    chk(rx_d, 8'h5a);
    chk(i2c, 1);
    ir(8'h80);
    ibe <= 1'b1;
    u_chs_mcu.hw(4);
    ir(8'h00);
    txb <= {1'b1, 8'h77};
    ir(8'h77);
    iw(8'h01, 8'h00, 1'b0);
    free <= 9'h012;
    ir(8'h12);
    free <= 9'h100;
    ir(8'hff);
    u_chs_mcu.start();
    u_chs_mcu.ib(8'hca, 1'b1, q, a);
    chk(a, 1); // Foreign address left unanswered
    u_chs_mcu.stop();
    sadr <= 7'h65;
    u_chs_mcu.start();
    u_chs_mcu.ib(8'hca, 1'b1, q, a);
    chk(a, 0); // Reconfigured address now answered
    u_chs_mcu.stop();
    sadr <= 7'h64;
    iw(8'h01, 8'h05, 1'b1);
    chk(n_rst, 2);
    iw(8'h01, 8'h00, 1'b1);
    chk(n_rst, 3);
    $display("Two-wire test done");
    end_sim();
  end

  // Watchdog well beyond the expected run
  initial
  begin
    repeat (40000) @(posedge clk);
    n_errors++;
    end_sim();
  end
endmodule
